// >>> design/pomc_pkg.sv
// Purpose: constants for the PROM overlay memory control block
// Assumes: 250 MHz clock, 12-bit memory words, 13th bit marks an indirect word
// Notes:   times are kept in picoseconds, cycle counts derived here
// How it works
// - Read cycle: field match and write flag low plus return phase fires 1.35 us latch strobe.
// - Latch strobe captures the selector output into a 12-bit holding latch.
// - Same moment starts 1.2 us cycle-extend pulse that lengthens the memory cycle.
// - Extend timer sets core inhibit only in the overlay variant.
// - Field match routes memory address bits 4..11 to every PROM chip.
// - With field match, buffered address bits 2,3 select exactly one PROM pair; 00 selects first.
// - Indirection bit chip is always selected, read on every access.
// - Indirection bit set: assert indirect flag, low PROM byte addresses scratch.
// - Scratch memory holds 256 twelve-bit words addressed by PROM bits 0..7.
// - Write: field match, indirection set, direction high, write enable at timing pulse three stores data.
// - Selector passes scratch data when indirection set, else PROM data.
// - Bus drivers enabled only with field match and buffered direction high.
// - Selector gives B when select high, A when low, strobe held low.
package pomc_pkg;
  localparam int WORD_W     = 12;
  localparam int PROM_W     = 13;
  localparam int SCR_AW     = 8;
  localparam int SCR_DEPTH  = 256;
  localparam int PAIR_N     = 4;
  localparam int CLK_PS     = 4000;
  localparam int LATCH_PS   = 1350000;
  localparam int EXTEND_PS  = 1200000;
  // Least times round up to whole cycles
  localparam int LATCH_CYC  = (LATCH_PS + CLK_PS - 1) / CLK_PS;
  localparam int EXTEND_CYC = (EXTEND_PS + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W      = 9;
  localparam int INDIRECT_BIT = 12;
  localparam int ADDR_LO    = 4;
  localparam int ADDR_HI    = 11;
  localparam logic [WORD_W-1:0] LATCH_RST = 12'h000;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 9'h000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 9'h001;
  typedef enum logic [2:0] {
    POMC_IDLE   = 3'b001,
    POMC_STROBE = 3'b010,
    POMC_HOLD   = 3'b100
  } pomc_state_type;
endpackage

// >>> design/pomc_scratch_mem.sv
// Purpose: 256 x 12 scratch read/write memory
// Assumes: one write port, registered read data
// Notes:   read data lags address by one clock
`timescale 1ns/1ps
`default_nettype none
module pomc_scratch_mem #(
  parameter int DW = 12,
  parameter int AW = 8
) (
  // Clock
  input  wire logic          clk,
  // Access
  input  wire logic [AW-1:0] addr,
  input  wire logic          writeEn,
  input  wire logic [DW-1:0] writeData,
  output logic      [DW-1:0] readData
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (writeEn) begin
      mem[addr] <= writeData;
    end
    readData <= mem[addr];
  end
endmodule
`default_nettype wire

// >>> design/pomc_data_select.sv
// Purpose: two-input word selector with strobe
// Assumes: strobe active high forces output low
// Notes:   purely combinational, as the quad selector parts
`timescale 1ns/1ps
`default_nettype none
module pomc_data_select #(
  parameter int DW = 12
) (
  // Select
  input  wire logic          sel,
  input  wire logic          strobe,
  // Data
  input  wire logic [DW-1:0] inA,
  input  wire logic [DW-1:0] inB,
  output logic      [DW-1:0] outY
);
  always_comb begin
    if (strobe) begin
      outY = '0;
    end else if (sel) begin
      outY = inB;
    end else begin
      outY = inA;
    end
  end
endmodule
`default_nettype wire

// >>> design/pomc_control.sv
// Purpose: read/write control of the PROM overlay memory option
// Assumes: bus signals arrive asynchronously and are synchronised here
// Notes:   PROM contents live outside; this block drives its address and selects
//          one read sequence per return phase; scratch writes need the indirection bit
`timescale 1ns/1ps
`default_nettype none
module pomc_control
  import pomc_pkg::*;
#(
  parameter int LATCH_CYCLES  = pomc_pkg::LATCH_CYC,
  parameter int EXTEND_CYCLES = pomc_pkg::EXTEND_CYC,
  parameter bit OVERLAY_CORE  = 1'b1
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Bus timing and control
  input  wire logic                       writeCycle,
  input  wire logic                       returnPhase,
  input  wire logic                       field_match,
  input  wire logic                       bus_data_direction,
  input  wire logic                       buffered_data_direction,
  input  wire logic                       timing_pulse_three,
  // Addressing
  input  wire logic [7:0]                 mem_addr_low_bits,
  input  wire logic                       buffered_block_addr_hi,
  input  wire logic                       buffered_block_addr_lo,
  // PROM chips
  output logic      [7:0]                 promAddr,
  output logic      [pomc_pkg::PAIR_N-1:0] promPairSelect_n,
  output logic                            indirectChipSelect_n,
  input  wire logic [pomc_pkg::PROM_W-1:0] promData,
  // Memory data bus
  input  wire logic [pomc_pkg::WORD_W-1:0] memory_data_bus_in,
  output logic      [pomc_pkg::WORD_W-1:0] memory_data_bus_out,
  output logic                            memory_data_bus_oe,
  // Timing logic and status
  output logic                            read_latch_strobe,
  output logic                            cycleExtend,
  output logic                            coreInhibit,
  output logic                            indirectFlag,
  output logic                            scratch_write_enable
);
  import pomc_pkg::*;

  // Two-stage synchronisers for every outside input
  // Metastability guard costs two cycles of latency on every bus signal
  logic [5:0] syncA;
  logic [5:0] syncB;
  logic [7:0] addrA;
  logic [7:0] addrB;
  logic [1:0] blkA;
  logic [1:0] blkB;
  logic [WORD_W-1:0] mdA;
  logic [WORD_W-1:0] mdB;
  logic [PROM_W-1:0] romA;
  logic [PROM_W-1:0] romB;

  // Timing and direction levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= {writeCycle, returnPhase, field_match, bus_data_direction,
                buffered_data_direction, timing_pulse_three};
      syncB <= syncA;
    end
  end

  // Memory address bits for the PROM chips
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addrA <= '0;
      addrB <= '0;
    end else begin
      addrA <= mem_addr_low_bits;
      addrB <= addrA;
    end
  end

  // Pair select bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blkA <= '0;
      blkB <= '0;
    end else begin
      blkA <= {buffered_block_addr_hi, buffered_block_addr_lo};
      blkB <= blkA;
    end
  end

  // Write data from the memory data bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mdA <= '0;
      mdB <= '0;
    end else begin
      mdA <= memory_data_bus_in;
      mdB <= mdA;
    end
  end

  // PROM word; must be steady a few cycles before the return phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      romA <= '0;
      romB <= '0;
    end else begin
      romA <= promData;
      romB <= romA;
    end
  end

  logic sWrite;
  logic sReturn;
  logic sField;
  logic sDir;
  logic sBufDir;
  logic sTp3;
  assign sWrite  = syncB[5];
  assign sReturn = syncB[4];
  assign sField  = syncB[3];
  assign sDir    = syncB[2];
  assign sBufDir = syncB[1];
  assign sTp3    = syncB[0];

  // Edge detectors read only second-stage flops
  // Reset value is the idle low level, so no false edge follows reset
  logic returnLast;
  logic tp3Last;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      returnLast <= 1'b0;
    end else begin
      returnLast <= sReturn;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tp3Last <= 1'b0;
    end else begin
      tp3Last <= sTp3;
    end
  end

  logic trigger;
  assign trigger = sReturn && !returnLast && !sWrite && sField;

  // One-hot pair decode, shared by both address bits
  function automatic logic [PAIR_N-1:0] pairDecode(input logic [1:0] blk);
    pairDecode = ~(4'h1 << blk);
  endfunction

  // Shared one-shot step: load on start, else run down to zero
  function automatic logic [CNT_W-1:0] oneShotNext(
    input logic             start,
    input logic [CNT_W-1:0] load,
    input logic [CNT_W-1:0] count
  );
    if (start) begin
      oneShotNext = load;
    end else if (count != CNT_ZERO) begin
      oneShotNext = count - CNT_ONE;
    end else begin
      oneShotNext = CNT_ZERO;
    end
  endfunction

  // One-shot output: high while its counter runs
  function automatic logic oneShotActive(input logic [CNT_W-1:0] count);
    oneShotActive = (count != CNT_ZERO);
  endfunction

  // PROM addressing
  always_comb begin
    promAddr             = sField ? addrB : 8'h00;
    promPairSelect_n     = sField ? pairDecode(blkB) : 4'hF;
    indirectChipSelect_n = 1'b0;
  end

  // Indirection decode
  logic indirect;
  assign indirect     = romB[INDIRECT_BIT];
  assign indirectFlag = sField && indirect;

  // Scratch memory, addressed by the low PROM byte
  logic [WORD_W-1:0] scratchData;
  logic              scratchWrite;
  assign scratchWrite = sField && indirect && sDir && sTp3 && !tp3Last;
  assign scratch_write_enable = scratchWrite;

  pomc_scratch_mem #(
    .DW(WORD_W),
    .AW(SCR_AW)
  ) uScratch (
    .clk      (clk),
    .addr     (romB[ADDR_HI-ADDR_LO:0]),
    .writeEn  (scratchWrite),
    .writeData(mdB),
    .readData (scratchData)
  );

  // Selector between PROM and scratch words
  logic [WORD_W-1:0] selected;
  pomc_data_select #(
    .DW(WORD_W)
  ) uSelect (
    .sel   (indirect),
    .strobe(1'b0),
    .inA   (romB[WORD_W-1:0]),
    .inB   (scratchData),
    .outY  (selected)
  );

  // Strobe and extend one-shots fire together
  // Counters stand in for analogue one-shots, so widths track the clock
  pomc_state_type   state;
  pomc_state_type   next_state;
  logic [CNT_W-1:0] latchCnt;
  logic [CNT_W-1:0] extendCnt;
  logic             fire;

  // Only an idle sequence accepts a new return phase
  assign fire = (state == POMC_IDLE) && trigger;

  always_comb begin
    next_state = state;
    case (state)
      POMC_IDLE: begin
        if (trigger) begin
          next_state = POMC_STROBE;
        end
      end
      POMC_STROBE: begin
        // Leave on the strobe's last cycle
        if (latchCnt == CNT_ONE) begin
          next_state = POMC_HOLD;
        end
      end
      POMC_HOLD: begin
        // Wait out the return phase: one read per return phase
        if (!sReturn) begin
          next_state = POMC_IDLE;
        end
      end
      default: begin
        next_state = POMC_IDLE;
      end
    endcase
  end

  // Sequence state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= POMC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Latch strobe one-shot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latchCnt <= CNT_ZERO;
    end else begin
      latchCnt <= oneShotNext(fire, CNT_W'(LATCH_CYCLES), latchCnt);
    end
  end

  // Cycle extend one-shot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extendCnt <= CNT_ZERO;
    end else begin
      extendCnt <= oneShotNext(fire, CNT_W'(EXTEND_CYCLES), extendCnt);
    end
  end

  assign read_latch_strobe = oneShotActive(latchCnt);
  assign cycleExtend       = oneShotActive(extendCnt);

  // Overlay variant only: inhibit set by the extend timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coreInhibit <= 1'b0;
    end else if (!OVERLAY_CORE) begin
      coreInhibit <= 1'b0;
    end else if (cycleExtend) begin
      coreInhibit <= 1'b1;
    end else if (state == POMC_IDLE) begin
      coreInhibit <= 1'b0;
    end
  end

  // Holding latch captured at the strobe's leading edge, held to cycle end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memory_data_bus_out <= LATCH_RST;
    end else if (fire) begin
      memory_data_bus_out <= selected;
    end
  end
  // Latch not reloaded until IDLE, so it stays put through the cycle

  // Drivers off between sequences, so core memory owns the bus then
  assign memory_data_bus_oe = sField && sBufDir && (state != POMC_IDLE);
endmodule
`default_nettype wire

// >>> verification/pomc_control_checker.sv
// Purpose: assertions on the pomc_control ports
// Assumes: one clock, async active high reset
// Notes:   pulse widths are counted in helper logic
`timescale 1ns/1ps
`default_nettype none
module pomc_control_checker
  import pomc_pkg::*;
#(
  parameter int LATCH_CYCLES  = pomc_pkg::LATCH_CYC,
  parameter int EXTEND_CYCLES = pomc_pkg::EXTEND_CYC,
  parameter bit OVERLAY_CORE  = 1'b1
) (
  // Watched ports
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic                         field_match,
  input wire logic                         bus_data_direction,
  input wire logic                         buffered_data_direction,
  input wire logic [pomc_pkg::PAIR_N-1:0]  promPairSelect_n,
  input wire logic                         indirectChipSelect_n,
  input wire logic [pomc_pkg::WORD_W-1:0]  memory_data_bus_out,
  input wire logic                         memory_data_bus_oe,
  input wire logic                         read_latch_strobe,
  input wire logic                         cycleExtend,
  input wire logic                         coreInhibit,
  input wire logic                         scratch_write_enable
);
  import pomc_pkg::*;
  logic [9:0] strobeCnt;
  logic [9:0] extendCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) strobeCnt <= 10'h000;
    else strobeCnt <= read_latch_strobe ? strobeCnt + 10'h001 : 10'h000;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) extendCnt <= 10'h000;
    else extendCnt <= cycleExtend ? extendCnt + 10'h001 : 10'h000;
  end
  strobe_width_a: assert property (
    $fell(read_latch_strobe) |-> strobeCnt == 10'(LATCH_CYCLES)) else $error("strobe width");
  extend_width_a: assert property (
    $fell(cycleExtend) |-> extendCnt == 10'(EXTEND_CYCLES)) else $error("extend width");
  extend_start_a: assert property (
    $rose(read_latch_strobe) |-> $rose(cycleExtend)) else $error("extend not with strobe");
  core_inhibit_a: assert property (
    $rose(cycleExtend) |-> ##[0:2] (coreInhibit == OVERLAY_CORE)) else $error("core inhibit");
  pair_onehot_a: assert property (
    field_match && $past(field_match, 3) |-> $onehot(~promPairSelect_n))
    else $error("pair select not one-hot");
  bit_chip_a: assert property (
    !indirectChipSelect_n) else $error("indirection chip deselected");
  // Inputs reach the control logic two cycles late through the synchronisers
  bus_enable_a: assert property (
    memory_data_bus_oe |-> $past(field_match, 2) && $past(buffered_data_direction, 2))
    else $error("bus enable");
  latch_hold_a: assert property (
    $past(read_latch_strobe) && read_latch_strobe |-> $stable(memory_data_bus_out))
    else $error("latch changed");
  write_pulse_a: assert property (
    scratch_write_enable |-> $past(field_match, 2) && $past(bus_data_direction, 2)
    ##1 !scratch_write_enable)
    else $error("scratch write pulse");
endmodule
`default_nettype wire

// >>> verification/pomc_prom_model.sv
// Purpose: PROM chip array seen by pomc_control
// Assumes: word = pair index and address, bit 12 set in addresses F0..FF
// Notes:   deselected pairs float, shown as a changing pattern
`timescale 1ns/1ps
`default_nettype none
module pomc_prom_model
  import pomc_pkg::*;
(
  // PROM pins
  input  wire logic [7:0]                  promAddr,
  input  wire logic [pomc_pkg::PAIR_N-1:0] promPairSelect_n,
  output logic      [pomc_pkg::PROM_W-1:0] promData
);
  logic [1:0] pair;
  logic       hit;
  always_comb begin
    hit = 1'b1;
    pair = 2'b00;
    case (promPairSelect_n)
      4'hE: pair = 2'b00;
      4'hD: pair = 2'b01;
      4'hB: pair = 2'b10;
      4'h7: pair = 2'b11;
      default: hit = 1'b0;
    endcase
    promData[12] = (promAddr[7:4] == 4'hF);
    promData[11:0] = hit ? {2'b00, pair, promAddr} : ~{4'h0, promAddr};
  end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Purpose: self-checking bench for pomc_control
// Assumes: short strobe and extend counts of 4 and 3 cycles
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pomc_pkg::*;
  logic clk, rst, writeCycle, returnPhase, field_match, timing_pulse_three;
  logic bus_data_direction, buffered_data_direction, buffered_block_addr_hi;
  logic buffered_block_addr_lo, indirectChipSelect_n, memory_data_bus_oe;
  logic read_latch_strobe, cycleExtend, coreInhibit, indirectFlag, scratch_write_enable;
  logic [7:0]        mem_addr_low_bits, promAddr;
  logic [PAIR_N-1:0] promPairSelect_n;
  logic [PROM_W-1:0] promData;
  logic [WORD_W-1:0] memory_data_bus_in, memory_data_bus_out;
  int                n_errors, n_compared;
  pomc_control #(.LATCH_CYCLES(4), .EXTEND_CYCLES(3), .OVERLAY_CORE(1'b1)) DUT (
    .clk(clk), .rst(rst), .writeCycle(writeCycle), .returnPhase(returnPhase),
    .field_match(field_match), .bus_data_direction(bus_data_direction),
    .buffered_data_direction(buffered_data_direction), .timing_pulse_three(timing_pulse_three),
    .mem_addr_low_bits(mem_addr_low_bits), .buffered_block_addr_hi(buffered_block_addr_hi),
    .buffered_block_addr_lo(buffered_block_addr_lo), .promAddr(promAddr),
    .promPairSelect_n(promPairSelect_n), .indirectChipSelect_n(indirectChipSelect_n),
    .promData(promData), .memory_data_bus_in(memory_data_bus_in),
    .memory_data_bus_out(memory_data_bus_out), .memory_data_bus_oe(memory_data_bus_oe),
    .read_latch_strobe(read_latch_strobe), .cycleExtend(cycleExtend),
    .coreInhibit(coreInhibit), .indirectFlag(indirectFlag),
    .scratch_write_enable(scratch_write_enable));
  pomc_prom_model prom (.promAddr(promAddr), .promPairSelect_n(promPairSelect_n),
    .promData(promData));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Long settle: address and PROM data each pass a synchroniser
  task automatic setup(input logic fm, input logic [7:0] a, input logic [1:0] p, input logic wr);
    field_match = fm;
    mem_addr_low_bits = a;
    {buffered_block_addr_hi, buffered_block_addr_lo} = p;
    writeCycle = wr;
    bus_data_direction = wr;
    buffered_data_direction = !wr;
    repeat (8) @(negedge clk);
  endtask
  task automatic read_word(input logic [7:0] a, input logic [1:0] p, input logic [11:0] exp);
    int         i;
    logic [3:0] pairExp;
    pairExp = (p == 2'b00) ? 4'hE : (p == 2'b01) ? 4'hD : (p == 2'b10) ? 4'hB : 4'h7;
    setup(1'b1, a, p, 1'b0);
    chk("prom address", 16'(promAddr), 16'(a));
    chk("pair select", 16'(promPairSelect_n), 16'(pairExp));
    chk("bit chip select", 16'(indirectChipSelect_n), 16'h0000);
    chk("indirect flag", 16'(indirectFlag), 16'(a[7:4] == 4'hF));
    returnPhase = 1'b1;
    for (i = 0; i < 20 && read_latch_strobe !== 1'b1; i++) @(negedge clk);
    chk("latch strobe", 16'(read_latch_strobe), 16'h0001);
    chk("cycle extend", 16'(cycleExtend), 16'h0001);
    chk("bus data", 16'(memory_data_bus_out), 16'(exp));
    chk("bus enable", 16'(memory_data_bus_oe), 16'h0001);
    repeat (6) @(negedge clk);
    chk("core inhibit", 16'(coreInhibit), 16'h0001);
    chk("held data", 16'(memory_data_bus_out), 16'(exp));
    returnPhase = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic write_word(input logic [7:0] a, input logic [11:0] d);
    int hits = 0;
    int strobes = 0;
    memory_data_bus_in = d;
    setup(1'b1, a, 2'b00, 1'b1);
    returnPhase = 1'b1;
    repeat (2) @(negedge clk);
    timing_pulse_three = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      hits += (scratch_write_enable === 1'b1);
      strobes += (read_latch_strobe === 1'b1);
    end
    chk("write pulses", 16'(hits), 16'h0001);
    chk("strobes in write", 16'(strobes), 16'h0000);
    timing_pulse_three = 1'b0;
    returnPhase = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic unselected;
    setup(1'b0, 8'h3C, 2'b10, 1'b0);
    chk("idle pairs", 16'(promPairSelect_n), 16'h000F);
    chk("idle address", 16'(promAddr), 16'h0000);
    chk("idle enable", 16'(memory_data_bus_oe), 16'h0000);
    returnPhase = 1'b1;
    repeat (6) @(negedge clk);
    chk("idle strobe", 16'(read_latch_strobe), 16'h0000);
    returnPhase = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst, writeCycle, returnPhase, field_match, timing_pulse_three} = 5'h10;
    {bus_data_direction, buffered_data_direction} = 2'h0;
    {buffered_block_addr_hi, buffered_block_addr_lo} = 2'h0;
    mem_addr_low_bits = 8'h00;
    memory_data_bus_in = 12'h000;
    n_errors = 0;
    n_compared = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    for (int p = 0; p < 4; p++) read_word(8'h12 + 8'(p), 2'(p), {2'b00, 2'(p), 8'h12 + 8'(p)});
    write_word(8'hF3, 12'hA5C);
    write_word(8'hF4, 12'h3E1);
    read_word(8'hF3, 2'b01, 12'hA5C);
    read_word(8'hF4, 2'b11, 12'h3E1);
    unselected;
    final_report;
  end
  initial begin
    #20000;
    n_errors++;
    final_report;
  end
endmodule
bind pomc_control pomc_control_checker #(.LATCH_CYCLES(LATCH_CYCLES),
  .EXTEND_CYCLES(EXTEND_CYCLES), .OVERLAY_CORE(OVERLAY_CORE)) checker_i (
  .clk(clk), .rst(rst), .field_match(field_match), .bus_data_direction(bus_data_direction),
  .buffered_data_direction(buffered_data_direction), .promPairSelect_n(promPairSelect_n),
  .indirectChipSelect_n(indirectChipSelect_n), .memory_data_bus_out(memory_data_bus_out),
  .memory_data_bus_oe(memory_data_bus_oe), .read_latch_strobe(read_latch_strobe),
  .cycleExtend(cycleExtend), .coreInhibit(coreInhibit),
  .scratch_write_enable(scratch_write_enable));
`default_nettype wire
